// file: rtl/lte_pkg.sv
// Purpose: shared constants and types for the encoder, timeout and event block
// Assumes: 32-bit register port with byte addresses, 16-bit counter, one kernel clock
// Notes: configuration reads back as written, with reserved bits reading zero
// Functional notes
// - Quadrature counts only between zero and wrap limit.
// - Both phases clock quadrature counts; phase order sets direction.
// - Direction change sets up or down flag; interrupt if enabled.
// - Polarity picks counted edges; other input gives direction.
// - Pulse-direction counts zero to wrap limit; the pin that pulses sets direction.
// - Pulse-direction ignores both inputs high.
// - Timeout on: trigger edge resets and restarts the counter.
// - Timeout on: match reached without trigger is a match event.
// - Each enabled event raises the interrupt.
// - Enable set after its flag raises no interrupt.
// - Match flag sets when count equals match value.
// - Wrap flag sets when count equals wrap limit.
// - Trigger flag sets on each selected trigger edge.
// - Done flags follow wrap limit and match writes.
// - Up and down interrupts enable separately.
// - Down flag on turning down, up flag on turning up.
`default_nettype none
package lte_pkg;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;
    localparam int EVT_W = 7;
    localparam int CFG_W = 26;
    localparam int TRG_SEL_W = 3;
    typedef logic [31:0] lte_word_t;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_CFG = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_MATCH = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_WRAP = 8'h18;
    localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h1C;
    localparam logic [CFG_W-1:0] CFG_WMASK = 26'h3FEEEDF;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] WRAP_RESET = 16'h0001;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_ONESHOT_BIT = 1;
    localparam int CTRL_CONT_BIT = 2;
    localparam logic [1:0] POL_RISE = 2'h0;
    localparam logic [1:0] POL_FALL = 2'h1;
    localparam logic [1:0] POL_BOTH = 2'h2;
    localparam logic [1:0] TRG_SOFT = 2'h0;
    localparam logic [1:0] TRG_RISE = 2'h1;
    localparam logic [1:0] TRG_FALL = 2'h2;
    localparam logic [1:0] TRG_BOTH = 2'h3;
    typedef struct packed {
        logic pulse_dir_decode_enable;
        logic quad_decode_enable;
        logic count_ext_mode;
        logic reload_mode;
        logic wave_pol;
        logic wave_mode;
        logic trigger_timeout_enable;
        logic [1:0] trg_edge;
        logic rsv16;
        logic [TRG_SEL_W-1:0] trg_sel;
        logic rsv12;
        logic [2:0] clock_divider_field;
        logic rsv8;
        logic [1:0] trg_filter;
        logic rsv5;
        logic [1:0] clk_filter;
        logic [1:0] edge_polarity_field;
        logic count_source_select;
    } lte_cfg_t;
    typedef struct packed {
        logic continuous_start_bit;
        logic one_shot;
        logic enable;
    } lte_ctrl_t;
    typedef struct packed {
        logic dir_down;
        logic dir_up;
        logic wrap_upd;
        logic match_upd;
        logic trig;
        logic wrap_hit;
        logic match_hit;
    } lte_evt_t;
    typedef enum logic [2:0] {
        LTE_ST_IDLE = 3'b001,
        LTE_ST_WAIT = 3'b010,
        LTE_ST_RUN = 3'b100
    } lte_state_t;
endpackage
`default_nettype wire

// file: rtl/lte_sync_edge.sv
// Purpose: two-flop synchroniser with edge detection for a group of pin inputs
// Assumes: inputs are asynchronous to mclk
// Notes: edges come from the second and third flops, never from the first
`default_nettype none
module lte_sync_edge #(
    parameter int WIDTH = 2
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise,
    output logic [WIDTH-1:0] fall
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic s1_reg, s2_reg, s3_reg;
            logic s1_next, s2_next, s3_next;
            always_comb
            begin
                s1_next = din[i];
                s2_next = s1_reg;
                s3_next = s2_reg;
            end
            always_ff @(posedge mclk or posedge reset)
            begin
                if (reset)
                begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                end
                else if (ce)
                begin
                    s1_reg <= s1_next;
                    s2_reg <= s2_next;
                    s3_reg <= s3_next;
                end
            end
            assign level[i] = s2_reg;
            assign rise[i] = s2_reg & ~s3_reg;
            assign fall[i] = ~s2_reg & s3_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// file: rtl/lte_event_flags.sv
// Purpose: sticky event flags with enable mask and one interrupt or wake-up output
// Assumes: clear is write-one-to-clear, one cycle wide
// Notes: a flag is only armed if its enable was on when the event came
`default_nettype none
module lte_event_flags #(
    parameter int N = 7
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [N-1:0] set_evt,
    input wire logic [N-1:0] clr_evt,
    input wire logic [N-1:0] mask,
    output logic [N-1:0] flags,
    output logic irq
);
    logic [N-1:0] flag_reg, flag_next, arm_reg, arm_next;
    logic irq_reg, irq_next;
    always_comb
    begin
        // Set beats clear so a coincident event survives
        flag_next = set_evt | (flag_reg & ~clr_evt);
        arm_next = mask & (set_evt | (arm_reg & flag_next));
        irq_next = |(flag_next & arm_next);
    end
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            flag_reg <= '0;
            arm_reg <= '0;
            irq_reg <= 1'b0;
        end
        else if (ce)
        begin
            flag_reg <= flag_next;
            arm_reg <= arm_next;
            irq_reg <= irq_next;
        end
    end
    assign flags = flag_reg;
    assign irq = irq_reg;
endmodule
`default_nettype wire

// file: rtl/lte_encoder_timer.sv
// Purpose: quadrature and pulse-direction decoding, trigger timeout and event flags
// Assumes: phase and trigger pins are asynchronous and pass two flops first
// Notes: without a decode mode the counter advances once per kernel clock
`default_nettype none
module lte_encoder_timer #(
    parameter int TRG_LINES = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [lte_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic [TRG_LINES-1:0] trigger_inputs,
    output logic event_irq
);
    lte_pkg::lte_cfg_t cfg_reg, cfg_next;
    lte_pkg::lte_ctrl_t ctrl_reg, ctrl_next;
    logic [lte_pkg::EVT_W-1:0] mask_reg, mask_next;
    logic [lte_pkg::CNT_W-1:0] match_reg, match_next;
    logic [lte_pkg::CNT_W-1:0] wrap_reg, wrap_next;
    logic [lte_pkg::CNT_W-1:0] count_reg, count_next;
    logic [31:0] rdata_reg, rdata_next;
    logic dir_up_reg, dir_up_next;
    lte_pkg::lte_state_t state_reg, state_next;
    logic [1:0] ph_level, ph_rise, ph_fall;
    logic [TRG_LINES-1:0] trg_level, trg_rise, trg_fall;
    logic a_l, b_l, a_r, b_r, a_f, b_f;
    logic use_r, use_f;
    logic q_up, q_dn, p_up, p_dn;
    logic quad_mode, pd_mode, step_up, step_dn;
    logic sel_rise, sel_fall, trig_evt;
    logic moved;
    logic wr_cfg, wr_ctrl, wr_mask, wr_clear, wr_match, wr_wrap;
    lte_pkg::lte_evt_t evt_set;
    logic [lte_pkg::EVT_W-1:0] evt_clr, evt_flags;

    lte_sync_edge #(
        .WIDTH(2)
    ) u_phase (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .din({phase_b_input, phase_a_input}),
        .level(ph_level),
        .rise(ph_rise),
        .fall(ph_fall)
    );

    lte_sync_edge #(
        .WIDTH(TRG_LINES)
    ) u_trig (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .din(trigger_inputs),
        .level(trg_level),
        .rise(trg_rise),
        .fall(trg_fall)
    );

    assign a_l = ph_level[0];
    assign b_l = ph_level[1];
    assign a_r = ph_rise[0];
    assign b_r = ph_rise[1];
    assign a_f = ph_fall[0];
    assign b_f = ph_fall[1];

    // Write decodes
    assign wr_cfg = reg_wr && (reg_addr == lte_pkg::OFF_CFG);
    assign wr_ctrl = reg_wr && (reg_addr == lte_pkg::OFF_CTRL);
    assign wr_mask = reg_wr && (reg_addr == lte_pkg::OFF_MASK);
    assign wr_clear = reg_wr && (reg_addr == lte_pkg::OFF_CLEAR);
    assign wr_match = reg_wr && (reg_addr == lte_pkg::OFF_MATCH);
    assign wr_wrap = reg_wr && (reg_addr == lte_pkg::OFF_WRAP);

    // Trigger selection and edge qualification
    always_comb
    begin
        sel_rise = trg_rise[cfg_reg.trg_sel];
        sel_fall = trg_fall[cfg_reg.trg_sel];
        case (cfg_reg.trg_edge)
            lte_pkg::TRG_RISE: trig_evt = sel_rise;
            lte_pkg::TRG_FALL: trig_evt = sel_fall;
            lte_pkg::TRG_BOTH: trig_evt = sel_rise | sel_fall;
            default: trig_evt = 1'b0;
        endcase
    end

    // Step decoding; the other input is steady when one switches
    always_comb
    begin
        use_r = (cfg_reg.edge_polarity_field == lte_pkg::POL_RISE) ||
                (cfg_reg.edge_polarity_field == lte_pkg::POL_BOTH);
        use_f = (cfg_reg.edge_polarity_field == lte_pkg::POL_FALL) ||
                (cfg_reg.edge_polarity_field == lte_pkg::POL_BOTH);
        q_up = (use_r & a_r & ~b_l) | (use_f & a_f & b_l) |
               (use_r & b_r & a_l) | (use_f & b_f & ~a_l);
        q_dn = (use_r & a_r & b_l) | (use_f & a_f & ~b_l) |
               (use_r & b_r & ~a_l) | (use_f & b_f & a_l);
        // Both high at once is not a valid pulse pattern
        p_up = a_r & ~b_l;
        p_dn = b_r & ~a_l;
        quad_mode = cfg_reg.quad_decode_enable;
        pd_mode = cfg_reg.pulse_dir_decode_enable & ~cfg_reg.quad_decode_enable;
        step_up = (quad_mode & q_up) | (pd_mode & p_up);
        step_dn = (quad_mode & q_dn) | (pd_mode & p_dn);
    end

    // Start control: decoding only runs once continuous mode has started
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            lte_pkg::LTE_ST_IDLE:
            begin
                if (ctrl_reg.enable && ctrl_reg.continuous_start_bit)
                begin
                    if (cfg_reg.trg_edge == lte_pkg::TRG_SOFT)
                        state_next = lte_pkg::LTE_ST_RUN;
                    else
                        state_next = lte_pkg::LTE_ST_WAIT;
                end
            end
            lte_pkg::LTE_ST_WAIT:
            begin
                if (trig_evt)
                    state_next = lte_pkg::LTE_ST_RUN;
            end
            lte_pkg::LTE_ST_RUN:
            begin
                state_next = lte_pkg::LTE_ST_RUN;
            end
            default:
            begin
                state_next = lte_pkg::LTE_ST_IDLE;
            end
        endcase
        if (!ctrl_reg.enable || !ctrl_reg.continuous_start_bit)
            state_next = lte_pkg::LTE_ST_IDLE;
    end

    // Counter and direction
    always_comb
    begin
        count_next = count_reg;
        dir_up_next = dir_up_reg;
        moved = 1'b0;
        if (state_reg != lte_pkg::LTE_ST_RUN)
        begin
            count_next = lte_pkg::CNT_ZERO;
        end
        else if (cfg_reg.trigger_timeout_enable && trig_evt)
        begin
            // Restart gives the counter a full match interval again
            count_next = lte_pkg::CNT_ZERO;
            moved = 1'b1;
        end
        else if (quad_mode || pd_mode)
        begin
            if (step_up)
            begin
                moved = 1'b1;
                dir_up_next = 1'b1;
                if (count_reg >= wrap_reg)
                    count_next = lte_pkg::CNT_ZERO;
                else
                    count_next = count_reg + lte_pkg::CNT_ONE;
            end
            else if (step_dn)
            begin
                moved = 1'b1;
                dir_up_next = 1'b0;
                if (count_reg == lte_pkg::CNT_ZERO || count_reg > wrap_reg)
                    count_next = wrap_reg;
                else
                    count_next = count_reg - lte_pkg::CNT_ONE;
            end
        end
        else
        begin
            moved = 1'b1;
            if (count_reg >= wrap_reg)
                count_next = lte_pkg::CNT_ZERO;
            else
                count_next = count_reg + lte_pkg::CNT_ONE;
        end
    end

    // Event sources
    always_comb
    begin
        evt_set.match_hit = moved && (count_next == match_reg);
        evt_set.wrap_hit = moved && (count_next == wrap_reg);
        evt_set.trig = trig_evt;
        evt_set.match_upd = wr_match;
        evt_set.wrap_upd = wr_wrap;
        evt_set.dir_up = (state_reg == lte_pkg::LTE_ST_RUN) && step_up &&
                         !dir_up_reg;
        evt_set.dir_down = (state_reg == lte_pkg::LTE_ST_RUN) && step_dn &&
                           dir_up_reg;
        evt_clr = wr_clear ? reg_wdata[lte_pkg::EVT_W-1:0] : '0;
    end

    lte_event_flags #(
        .N(lte_pkg::EVT_W)
    ) u_flags (
        .mclk(mclk),
        .reset(reset),
        .ce(ce),
        .set_evt(evt_set),
        .clr_evt(evt_clr),
        .mask(mask_reg),
        .flags(evt_flags),
        .irq(event_irq)
    );

    // Register file
    always_comb
    begin
        cfg_next = cfg_reg;
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        match_next = match_reg;
        wrap_next = wrap_reg;
        rdata_next = '0;
        if (wr_cfg)
            cfg_next = lte_pkg::lte_cfg_t'(reg_wdata[lte_pkg::CFG_W-1:0] & lte_pkg::CFG_WMASK);
        if (wr_mask)
            mask_next = reg_wdata[lte_pkg::EVT_W-1:0];
        if (wr_match)
            match_next = reg_wdata[lte_pkg::CNT_W-1:0];
        if (wr_wrap)
            wrap_next = reg_wdata[lte_pkg::CNT_W-1:0];
        if (wr_ctrl)
        begin
            // Start bits only take while the timer is enabled
            ctrl_next.enable = reg_wdata[lte_pkg::CTRL_EN_BIT];
            if (ctrl_reg.enable && reg_wdata[lte_pkg::CTRL_EN_BIT])
            begin
                ctrl_next.one_shot = ctrl_reg.one_shot | reg_wdata[lte_pkg::CTRL_ONESHOT_BIT];
                ctrl_next.continuous_start_bit = ctrl_reg.continuous_start_bit |
                                                 reg_wdata[lte_pkg::CTRL_CONT_BIT];
            end
            else
            begin
                ctrl_next.one_shot = 1'b0;
                ctrl_next.continuous_start_bit = 1'b0;
            end
        end
        if (reg_rd)
        begin
            case (reg_addr)
                lte_pkg::OFF_FLAGS: rdata_next = lte_pkg::lte_word_t'(evt_flags);
                lte_pkg::OFF_MASK: rdata_next = lte_pkg::lte_word_t'(mask_reg);
                lte_pkg::OFF_CFG: rdata_next = lte_pkg::lte_word_t'(cfg_reg);
                lte_pkg::OFF_CTRL: rdata_next = lte_pkg::lte_word_t'(ctrl_reg);
                lte_pkg::OFF_MATCH: rdata_next = lte_pkg::lte_word_t'(match_reg);
                lte_pkg::OFF_WRAP: rdata_next = lte_pkg::lte_word_t'(wrap_reg);
                lte_pkg::OFF_COUNT: rdata_next = lte_pkg::lte_word_t'(count_reg);
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            cfg_reg <= '0;
            ctrl_reg <= '0;
            mask_reg <= '0;
            match_reg <= lte_pkg::CNT_ZERO;
            wrap_reg <= lte_pkg::WRAP_RESET;
            count_reg <= lte_pkg::CNT_ZERO;
            dir_up_reg <= 1'b1;
            state_reg <= lte_pkg::LTE_ST_IDLE;
            rdata_reg <= '0;
        end
        else if (ce)
        begin
            cfg_reg <= cfg_next;
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            match_reg <= match_next;
            wrap_reg <= wrap_next;
            count_reg <= count_next;
            dir_up_reg <= dir_up_next;
            state_reg <= state_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;
endmodule
`default_nettype wire

// file: tb/lte_timer_props.sv
// Purpose: bus and event relations watched at the timer block ports
// Assumes: limit written only while stopped; mask may also be rewritten while running
// Notes: mask and wrap limit are shadowed here from the register port
`default_nettype none
module lte_timer_props #(
    parameter int TRG_LINES = 8
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [lte_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic [TRG_LINES-1:0] trigger_inputs,
    input wire logic event_irq
);
    logic [6:0] mask_reg, mask_next;
    logic [15:0] wrap_reg, wrap_next;
    wire logic rd_take = reg_rd && ce;
    wire logic wr_take = reg_wr && ce;
    always_comb
    begin
        mask_next = mask_reg;
        wrap_next = wrap_reg;
        if (wr_take && reg_addr == lte_pkg::OFF_MASK)
            mask_next = reg_wdata[6:0];
        if (wr_take && reg_addr == lte_pkg::OFF_WRAP)
            wrap_next = reg_wdata[15:0];
    end
    always_ff @(posedge mclk or posedge reset)
    begin
        if (reset)
        begin
            mask_reg <= 7'h00;
            wrap_reg <= 16'h0001;
        end
        else
        begin
            mask_reg <= mask_next;
            wrap_reg <= wrap_next;
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);
    chk_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h0)
        else $error("idle read data not zero");
    chk_unmapped_zero: assert property (rd_take && reg_addr > lte_pkg::OFF_COUNT |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_clear_reads_zero: assert property (rd_take && reg_addr == lte_pkg::OFF_CLEAR |=> reg_rdata == 32'h0)
        else $error("clear read not zero");
    chk_wrap_done_flag: assert property (wr_take && reg_addr == lte_pkg::OFF_WRAP ##1 !reg_wr ##1
        rd_take && reg_addr == lte_pkg::OFF_FLAGS |=> reg_rdata[4]) else $error("limit write done missing");
    chk_match_done_flag: assert property (wr_take && reg_addr == lte_pkg::OFF_MATCH ##1 !reg_wr ##1
        rd_take && reg_addr == lte_pkg::OFF_FLAGS |=> reg_rdata[3]) else $error("match write done missing");
    chk_irq_needs_mask: assert property (event_irq |-> mask_reg != 7'h00 ||
        $past(mask_reg) != 7'h00 || $past(mask_reg, 2) != 7'h00) else $error("interrupt with no enable");
    chk_count_in_range: assert property (rd_take && reg_addr == lte_pkg::OFF_COUNT |=>
        reg_rdata[15:0] <= wrap_reg && reg_rdata[31:16] == 16'h0000) else $error("count above limit");
    chk_mask_readback: assert property (rd_take && reg_addr == lte_pkg::OFF_MASK |=>
        reg_rdata[6:0] == $past(mask_reg)) else $error("enable mask readback wrong");
    cover property ($rose(event_irq));
    cover property (phase_a_input && phase_b_input);
    cover property (trigger_inputs[0] && rd_take);
endmodule
bind lte_encoder_timer lte_timer_props #(.TRG_LINES(TRG_LINES)) u_props (
    .mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .phase_a_input(phase_a_input),
    .phase_b_input(phase_b_input), .trigger_inputs(trigger_inputs), .event_irq(event_irq));
`default_nettype wire

// file: tb/lte_enc_model.sv
// Purpose: incremental encoder driving the two phase pins
// Assumes: caller runs one step at a time
// Notes: each change held HOLD cycles
`default_nettype none
module lte_enc_model (
    input wire logic mclk,
    output logic phase_a,
    output logic phase_b
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HOLD = 6;
    initial
    begin
        phase_a = 1'b0;
        phase_b = 1'b0;
    end
    // Holding each level keeps the toggle rate under a quarter of mclk
    task automatic set_pins(input logic a, input logic b);
        @(posedge mclk);
        phase_a <= a;
        phase_b <= b;
        repeat (HOLD) @(posedge mclk);
    endtask
    // Gray order 00,10,11,01 turns forward; only one pin moves per step
    task automatic quad_step(input logic up);
        if ((phase_a == phase_b) == up)
            set_pins(~phase_a, phase_b);
        else
            set_pins(phase_a, ~phase_b);
    endtask
    task automatic pulse(input logic up);
        set_pins(up, ~up);
        set_pins(1'b0, 1'b0);
    endtask
    // Second pin rises while the first is still high
    task automatic overlap;
        set_pins(1'b1, 1'b0);
        set_pins(1'b1, 1'b1);
        set_pins(1'b0, 1'b1);
        set_pins(1'b0, 1'b0);
    endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: self-checking bench for the encoder, timeout and event block
// Assumes: ce drops only in the freeze check
// Notes: limit is rewritten only while the timer is stopped; mask is also rewritten while it runs
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk;
    logic reset;
    logic [lte_pkg::ADDR_W-1:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic phase_a;
    logic phase_b;
    logic [7:0] trig;
    logic event_irq;
    logic ce;
    logic [31:0] d;
    int failures;
    int n_compared;
    int cycles;
    lte_enc_model enc (.mclk(mclk), .phase_a(phase_a), .phase_b(phase_b));
    lte_encoder_timer #(.TRG_LINES(8)) dut (.mclk(mclk), .reset(reset), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .phase_a_input(phase_a), .phase_b_input(phase_b),
        .trigger_inputs(trig), .event_irq(event_irq));
    always #2.5 mclk = ~mclk;
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard: the whole run needs well under this many cycles
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            failures = failures + 1;
            conclude();
        end
    end
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            failures = failures + 1;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp, what);
    endtask
    task automatic start;
        wr(lte_pkg::OFF_CTRL, 32'h1);
        wr(lte_pkg::OFF_CTRL, 32'h5);
    endtask
    task automatic t_reset_values;
        for (int i = 0; i < 9; i++)
            chk_rd(8'(i * 4), (i == 6) ? 32'h1 : 32'h0, "reset value");
        $display("reset values done");
    endtask
    task automatic t_polarity;
        logic [31:0] exp [4] = '{32'h2, 32'h2, 32'h4, 32'h0};
        for (int p = 0; p < 4; p++)
        begin
            wr(lte_pkg::OFF_CTRL, 32'h0);
            wr(lte_pkg::OFF_WRAP, 32'h64);
            wr(lte_pkg::OFF_CFG, 32'h1000000 | 32'(p << 1));
            start();
            repeat (4) enc.quad_step(1'b1);
            idle(6);
            chk_rd(lte_pkg::OFF_COUNT, exp[p], "edge polarity count");
        end
        $display("polarity done");
    endtask
    task automatic t_quad_wrap;
        wr(lte_pkg::OFF_CTRL, 32'h0);
        wr(lte_pkg::OFF_WRAP, 32'h3);
        wr(lte_pkg::OFF_CFG, 32'h1000004);
        wr(lte_pkg::OFF_CLEAR, 32'h7F);
        wr(lte_pkg::OFF_MASK, 32'h40);
        start();
        repeat (3) enc.quad_step(1'b1);
        idle(6);
        chk_rd(lte_pkg::OFF_COUNT, 32'h3, "count at limit");
        rd(lte_pkg::OFF_FLAGS, d);
        chk(d & 32'h62, 32'h2, "limit flag only");
        enc.quad_step(1'b1);
        idle(6);
        chk_rd(lte_pkg::OFF_COUNT, 32'h0, "wrap up to zero");
        enc.quad_step(1'b0);
        idle(6);
        chk_rd(lte_pkg::OFF_COUNT, 32'h3, "wrap down to limit");
        rd(lte_pkg::OFF_FLAGS, d);
        chk(d & 32'h60, 32'h40, "down flag");
        chk(32'(event_irq), 32'h1, "down interrupt");
        wr(lte_pkg::OFF_CLEAR, 32'h7F);
        wr(lte_pkg::OFF_MASK, 32'h20);
        idle(3);
        chk(32'(event_irq), 32'h0, "interrupt after clear");
        enc.quad_step(1'b0);
        idle(6);
        chk(32'(event_irq), 32'h0, "no change no interrupt");
        enc.quad_step(1'b1);
        idle(6);
        chk(32'(event_irq), 32'h1, "up interrupt");
        wr(lte_pkg::OFF_MASK, 32'h0);
        $display("quadrature wrap done");
    endtask
    task automatic t_pulse;
        wr(lte_pkg::OFF_CTRL, 32'h0);
        wr(lte_pkg::OFF_CFG, 32'h2000000);
        wr(lte_pkg::OFF_CLEAR, 32'h7F);
        start();
        repeat (3) enc.pulse(1'b1);
        enc.pulse(1'b0);
        idle(6);
        chk_rd(lte_pkg::OFF_COUNT, 32'h2, "pulse count");
        enc.overlap();
        idle(6);
        chk_rd(lte_pkg::OFF_COUNT, 32'h3, "overlap ignored");
        rd(lte_pkg::OFF_FLAGS, d);
        chk(d & 32'h60, 32'h60, "both direction flags");
        $display("pulse direction done");
    endtask
    task automatic t_timeout;
        wr(lte_pkg::OFF_CTRL, 32'h0);
        wr(lte_pkg::OFF_WRAP, 32'h3E8);
        wr(lte_pkg::OFF_CFG, 32'hA0000);
        wr(lte_pkg::OFF_MATCH, 32'h14);
        rd(lte_pkg::OFF_FLAGS, d);
        chk(d & 32'h18, 32'h18, "write done flags");
        wr(lte_pkg::OFF_CLEAR, 32'h7F);
        wr(lte_pkg::OFF_MASK, 32'h1);
        start();
        // Triggers every 12 cycles keep the count below the match of 20
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            trig <= 8'h01;
            idle(6);
            trig <= 8'h00;
            idle(5);
        end
        rd(lte_pkg::OFF_FLAGS, d);
        chk(d & 32'h5, 32'h4, "trigger flag, no match");
        idle(30);
        rd(lte_pkg::OFF_FLAGS, d);
        chk(d & 32'h1, 32'h1, "timeout match");
        chk(32'(event_irq), 32'h1, "match interrupt");
        // Ten frozen edges: only three counting edges lie between the two reads
        rd(lte_pkg::OFF_COUNT, d);
        @(posedge mclk);
        ce <= 1'b0;
        idle(10);
        ce <= 1'b1;
        chk_rd(lte_pkg::OFF_COUNT, d + 32'h3, "count frozen by ce");
        wr(lte_pkg::OFF_CTRL, 32'h0);
        $display("timeout done");
    endtask
    task automatic t_mask_late;
        wr(lte_pkg::OFF_MASK, 32'h0);
        wr(lte_pkg::OFF_CLEAR, 32'h7F);
        wr(lte_pkg::OFF_WRAP, 32'h5);
        rd(lte_pkg::OFF_FLAGS, d);
        chk(d & 32'h10, 32'h10, "limit write done");
        wr(lte_pkg::OFF_MASK, 32'h10);
        idle(3);
        chk(32'(event_irq), 32'h0, "late enable stays quiet");
        wr(lte_pkg::OFF_WRAP, 32'h6);
        idle(2);
        chk(32'(event_irq), 32'h1, "enabled write done");
        $display("late mask done");
    endtask
    initial
    begin
        mclk = 1'b0;
        reset = 1'b1;
        ce = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        trig = 8'h00;
        failures = 0;
        n_compared = 0;
        cycles = 0;
        idle(12);
        reset <= 1'b0;
        t_reset_values();
        t_polarity();
        t_quad_wrap();
        t_pulse();
        t_timeout();
        t_mask_late();
        conclude();
    end
endmodule
`default_nettype wire
